// *** bwsb_host_model.sv ***
// Host controller model that reads and clears status registers on the access port.
// Assumes the bank takes a request on the rising edge and answers one edge later.
`timescale 1ns/1ps
module bwsb_host_model
  import bwsb_pkg::*;
(
  input  wire logic              clk,
  input  wire logic [DATA_W-1:0] readData,
  input  wire logic              readValid,
  output logic                   accessValid,
  output logic                   accessWrite,
  output logic      [ADDR_W-1:0] accessAddr,
  output logic      [DATA_W-1:0] writeData
);
  initial
  begin
    accessValid = 1'b0;
    accessWrite = 1'b0;
    accessAddr  = 7'h00;
    writeData   = 8'h00;
  end

  // A write with zero bits is how the host clears flags to see new events.
  task automatic access(input logic isWrite, input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] q);
    @(posedge clk);
    accessValid <= 1'b1;
    accessWrite <= isWrite;
    accessAddr  <= a;
    writeData   <= d;
    @(posedge clk);
    accessValid <= 1'b0;
    #1;
    q = (isWrite || readValid === 1'b1) ? readData : 8'hxx;
  endtask
endmodule

// *** bwsb_pkg.sv ***
// Package of constants and types for the bus, wake and switch status bank.
// Assumes a 125 MHz system clock and a 7-bit register address from the serial port.
package bwsb_pkg;

  localparam int unsigned ADDR_W = 7;
  localparam int unsigned DATA_W = 8;

  localparam logic [6:0] ADDR_SECOND_LIN_BUS_STATUS      = 7'h45;
  localparam logic [6:0] ADDR_WAKE_SOURCE_STATUS_ONE     = 7'h46;
  localparam logic [6:0] ADDR_WAKE_SOURCE_STATUS_TWO     = 7'h47;
  localparam logic [6:0] ADDR_WAKE_INPUT_LEVEL_STATUS    = 7'h48;
  localparam logic [6:0] ADDR_HIGH_SIDE_OVERLOAD_STATUS  = 7'h54;
  localparam logic [6:0] ADDR_HIGH_SIDE_OPEN_LOAD_STATUS = 7'h55;

  localparam logic [7:0] RESET_STATUS = 8'h00;

  localparam int unsigned FAULT_LSB       = 1;
  localparam int unsigned WK1_LIN2_BIT    = 7;
  localparam int unsigned WK1_LIN1_BIT    = 6;
  localparam int unsigned WK1_CAN_BIT     = 5;
  localparam int unsigned WK1_TIMER_BIT   = 4;
  localparam int unsigned WK1_INPUT_LSB   = 0;
  localparam int unsigned WK2_GP_LSB      = 4;
  localparam int unsigned LVL_DEV_BIT     = 7;
  localparam int unsigned LVL_PULLUP_BIT  = 6;
  localparam int unsigned LVL_GP_LSB      = 4;
  localparam int unsigned LVL_WK_LSB      = 0;
  localparam int unsigned HS_COUNT        = 4;
  localparam int unsigned WK_COUNT        = 3;
  localparam int unsigned GP_COUNT        = 2;

  localparam logic [1:0] FAULT_NONE     = 2'h0;
  localparam logic [1:0] FAULT_THERMAL  = 2'h1;
  localparam logic [1:0] FAULT_TXD_DOM  = 2'h2;
  localparam logic [1:0] FAULT_BUS_DOM  = 2'h3;

  localparam int unsigned CLK_PERIOD_NS     = 8;
  localparam int unsigned TX_ENABLE_TIME_NS = 10000;
  localparam int unsigned TX_ENABLE_CYCLES  =
    (TX_ENABLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    BWSB_MODE_INIT,
    BWSB_MODE_NORMAL,
    BWSB_MODE_STOP,
    BWSB_MODE_SLEEP,
    BWSB_MODE_RESTART,
    BWSB_MODE_FAILSAFE
  } bwsb_mode_t;

  typedef enum logic [1:0] {
    BWSB_GP_OFF,
    BWSB_GP_WAKE_INPUT,
    BWSB_GP_LOW_SIDE,
    BWSB_GP_HIGH_SIDE
  } bwsb_gp_cfg_t;

  typedef struct packed {
    logic                lin2;
    logic                lin1;
    logic                can;
    logic                timer;
    logic [WK_COUNT-1:0] wakeInput;
    logic [GP_COUNT-1:0] gpPin;
  } bwsb_wake_t;

  typedef struct packed {
    logic thermal;
    logic txdTimeout;
    logic busTimeout;
    logic txdHigh;
    logic busRecessive;
    logic txOff;
    logic supplyOk;
  } bwsb_lin_t;

endpackage

// *** bwsb_status_bank.sv ***
// Status register bank for second LIN faults, wake sources, levels and switch flags.
// Assumes a serial register port that issues one-cycle access strobes on clk.
`timescale 1ns/1ps
module bwsb_status_bank
  import bwsb_pkg::*;
#(
  parameter int unsigned ENABLE_CYCLES = TX_ENABLE_CYCLES
)
(
  input  wire logic                clk,
  input  wire logic                resetn,
  input  wire logic                softReset,
  input  wire logic                accessValid,
  input  wire logic                accessWrite,
  input  wire logic [ADDR_W-1:0]   accessAddr,
  input  wire logic [DATA_W-1:0]   writeData,
  output logic      [DATA_W-1:0]   readData,
  output logic                     readValid,
  input  wire bwsb_lin_t           lin2,
  output logic                     lin2TxEnable,
  input  wire bwsb_wake_t          wakeEvent,
  input  wire logic                failSafeWake,
  input  wire bwsb_wake_t          failSafeWakeSrc,
  input  wire bwsb_mode_t          sbcMode,
  input  wire bwsb_gp_cfg_t        gpCfg1,
  input  wire bwsb_gp_cfg_t        gpCfg2,
  input  wire logic [GP_COUNT-1:0] gpPinLevel,
  input  wire logic [WK_COUNT-1:0] wakePinLevel,
  input  wire logic                cyclicActive,
  input  wire logic                sampleStrobe,
  input  wire logic [WK_COUNT-1:0] sampledLevel,
  input  wire logic                testPinStrap,
  input  wire logic                intPullupDetect,
  input  wire logic [HS_COUNT-1:0] hsOverloadEvt,
  input  wire logic [HS_COUNT-1:0] hsOpenLoadEvt,
  input  wire logic                supplyLowRange,
  output logic                     hsOverloadCaution
);

  logic [1:0]          faultCode_q;
  logic [1:0]          faultCode_d;
  logic [7:0]          wakeOne_q;
  logic [7:0]          wakeOne_d;
  logic [GP_COUNT-1:0] wakeGp_q;
  logic [GP_COUNT-1:0] wakeGp_d;
  logic [HS_COUNT-1:0] overload_q;
  logic [HS_COUNT-1:0] overload_d;
  logic [HS_COUNT-1:0] openLoad_q;
  logic [HS_COUNT-1:0] openLoad_d;
  logic                strapDev_q;
  logic                strapDev_d;
  logic                strapPullup_q;
  logic                strapPullup_d;
  logic                strapTaken_q;
  logic                strapTaken_d;
  logic [GP_COUNT-1:0] gpLevel_q;
  logic [GP_COUNT-1:0] gpLevel_d;
  logic [WK_COUNT-1:0] wkLevel_q;
  logic [WK_COUNT-1:0] wkLevel_d;
  logic [DATA_W-1:0]   readData_q;
  logic [DATA_W-1:0]   readData_d;
  logic                readValid_q;
  logic                readValid_d;
  logic                caution_q;
  logic                caution_d;
  logic                txEnableRaw;
  logic                wrStrobe;
  logic                rdStrobe;
  logic                wrSecondLin;
  logic                wrWakeOne;
  logic                wrWakeTwo;
  logic                wrOverload;
  logic                wrOpenLoad;
  logic [DATA_W-1:0]   keep;
  logic [1:0]          faultEvt;
  logic [7:0]          wakeOneSet;
  logic [GP_COUNT-1:0] wakeGpSet;
  logic [GP_COUNT-1:0] gpUpdate;
  logic [DATA_W-1:0]   regLevel;
  bwsb_gp_cfg_t        gpCfg [GP_COUNT];

  bwsb_tx_recovery #(
    .ENABLE_CYCLES (ENABLE_CYCLES)
  ) u_tx_recovery (
    .clk      (clk),
    .resetn   (resetn),
    .lin      (lin2),
    .txEnable (txEnableRaw)
  );

  // A write clears every flag whose data bit is written as zero.
  assign wrStrobe = accessValid && accessWrite;
  assign keep     = writeData;
  assign rdStrobe = accessValid && !accessWrite;

  // Per-register write selects; the level register has nothing to clear.
  assign wrSecondLin = wrStrobe && (accessAddr == ADDR_SECOND_LIN_BUS_STATUS);
  assign wrWakeOne   = wrStrobe && (accessAddr == ADDR_WAKE_SOURCE_STATUS_ONE);
  assign wrWakeTwo   = wrStrobe && (accessAddr == ADDR_WAKE_SOURCE_STATUS_TWO);
  assign wrOverload  = wrStrobe && (accessAddr == ADDR_HIGH_SIDE_OVERLOAD_STATUS);
  assign wrOpenLoad  = wrStrobe && (accessAddr == ADDR_HIGH_SIDE_OPEN_LOAD_STATUS);
  assign gpCfg[0] = gpCfg1;
  assign gpCfg[1] = gpCfg2;

  // Second LIN fault code; a new detection outranks a clear in the same cycle.
  always_comb
  begin
    faultEvt = FAULT_NONE;
    if (lin2.thermal)
    begin
      faultEvt = FAULT_THERMAL;
    end
    else if (lin2.txdTimeout)
    begin
      faultEvt = FAULT_TXD_DOM;
    end
    else if (lin2.busTimeout)
    begin
      faultEvt = FAULT_BUS_DOM;
    end
    faultCode_d = faultCode_q;
    if (wrSecondLin)
    begin
      faultCode_d = faultCode_q & keep[FAULT_LSB +: 2];
    end
    if (faultEvt != FAULT_NONE)
    begin
      faultCode_d = faultEvt;
    end
    if (softReset)
    begin
      faultCode_d = FAULT_NONE;
    end
  end

  // Wake source flags, from live wake events and from a fail-safe exit.
  always_comb
  begin
    wakeOneSet = '0;
    wakeOneSet[WK1_LIN2_BIT]  = wakeEvent.lin2  || (failSafeWake && failSafeWakeSrc.lin2);
    wakeOneSet[WK1_LIN1_BIT]  = wakeEvent.lin1  || (failSafeWake && failSafeWakeSrc.lin1);
    wakeOneSet[WK1_CAN_BIT]   = wakeEvent.can   || (failSafeWake && failSafeWakeSrc.can);
    wakeOneSet[WK1_TIMER_BIT] = wakeEvent.timer || (failSafeWake && failSafeWakeSrc.timer);
    wakeOneSet[WK1_INPUT_LSB +: WK_COUNT] = wakeEvent.wakeInput |
      ({WK_COUNT{failSafeWake}} & failSafeWakeSrc.wakeInput);
    wakeGpSet = wakeEvent.gpPin |
      ({GP_COUNT{failSafeWake}} & failSafeWakeSrc.gpPin);
    wakeOne_d = wakeOne_q;
    wakeGp_d  = wakeGp_q;
    if (wrWakeOne)
    begin
      wakeOne_d = wakeOne_q & keep;
    end
    if (wrWakeTwo)
    begin
      wakeGp_d = wakeGp_q & keep[WK2_GP_LSB +: GP_COUNT];
    end
    wakeOne_d = wakeOne_d | wakeOneSet;
    wakeGp_d  = wakeGp_d | wakeGpSet;
    if (softReset)
    begin
      wakeOne_d = RESET_STATUS;
      wakeGp_d  = '0;
    end
  end

  // High-side switch overload and open-load flags, one slice per switch.
  for (genvar i = 0; i < HS_COUNT; i++)
  begin : g_hs
    always_comb
    begin
      overload_d[i] = overload_q[i];
      openLoad_d[i] = openLoad_q[i];
      if (wrOverload && !keep[i])
      begin
        overload_d[i] = 1'b0;
      end
      if (wrOpenLoad && !keep[i])
      begin
        openLoad_d[i] = 1'b0;
      end
      if (hsOverloadEvt[i])
      begin
        overload_d[i] = 1'b1;
      end
      if (hsOpenLoadEvt[i])
      begin
        openLoad_d[i] = 1'b1;
      end
      if (softReset)
      begin
        overload_d[i] = 1'b0;
        openLoad_d[i] = 1'b0;
      end
    end
  end

  // Pin and strap levels.
  for (genvar g = 0; g < GP_COUNT; g++)
  begin : g_gp
    assign gpUpdate[g] = (sbcMode == BWSB_MODE_NORMAL || sbcMode == BWSB_MODE_STOP) &&
                         (gpCfg[g] == BWSB_GP_WAKE_INPUT || gpCfg[g] == BWSB_GP_LOW_SIDE ||
                          gpCfg[g] == BWSB_GP_HIGH_SIDE);
  end

  always_comb
  begin
    strapTaken_d  = 1'b1;
    strapDev_d    = strapDev_q;
    strapPullup_d = strapPullup_q;
    if (!strapTaken_q)
    begin
      strapDev_d    = testPinStrap;
      strapPullup_d = intPullupDetect;
    end
    for (int k = 0; k < GP_COUNT; k++)
    begin
      gpLevel_d[k] = gpUpdate[k] ? gpPinLevel[k] : gpLevel_q[k];
    end
    wkLevel_d = wkLevel_q;
    if (!cyclicActive)
    begin
      wkLevel_d = wakePinLevel;
    end
    else if (sampleStrobe)
    begin
      wkLevel_d = sampledLevel;
    end
  end

  // Read path; unmapped addresses and reserved bits read as zero.
  always_comb
  begin
    regLevel = '0;
    regLevel[LVL_DEV_BIT]               = strapDev_q;
    regLevel[LVL_PULLUP_BIT]            = strapPullup_q;
    regLevel[LVL_GP_LSB +: GP_COUNT]    = gpLevel_q;
    regLevel[LVL_WK_LSB +: WK_COUNT]    = wkLevel_q;
    readData_d  = readData_q;
    readValid_d = rdStrobe;
    if (rdStrobe)
    begin
      readData_d = '0;
      case (accessAddr)
        ADDR_SECOND_LIN_BUS_STATUS:      readData_d[FAULT_LSB +: 2] = faultCode_q;
        ADDR_WAKE_SOURCE_STATUS_ONE:     readData_d = wakeOne_q;
        ADDR_WAKE_SOURCE_STATUS_TWO:     readData_d[WK2_GP_LSB +: GP_COUNT] = wakeGp_q;
        ADDR_WAKE_INPUT_LEVEL_STATUS:    readData_d = regLevel;
        ADDR_HIGH_SIDE_OVERLOAD_STATUS:  readData_d[HS_COUNT-1:0] = overload_q;
        ADDR_HIGH_SIDE_OPEN_LOAD_STATUS: readData_d[HS_COUNT-1:0] = openLoad_q;
        default:                         readData_d = '0;
      endcase
    end
  end

  // Overload caution follows the supply range one cycle late.
  always_comb
  begin
    caution_d = supplyLowRange;
  end

  // Asynchronous reset is power-on; a restart touches none of these flags.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      faultCode_q <= FAULT_NONE;
    end
    else
    begin
      faultCode_q <= faultCode_d;
    end
  end

  // Registers the wake source flags.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wakeOne_q <= RESET_STATUS;
      wakeGp_q  <= '0;
    end
    else
    begin
      wakeOne_q <= wakeOne_d;
      wakeGp_q  <= wakeGp_d;
    end
  end

  // Registers the high-side switch flags.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      overload_q <= '0;
      openLoad_q <= '0;
    end
    else
    begin
      overload_q <= overload_d;
      openLoad_q <= openLoad_d;
    end
  end

  // Registers the straps and the pin levels.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      strapDev_q    <= 1'b0;
      strapPullup_q <= 1'b0;
      strapTaken_q  <= 1'b0;
      gpLevel_q     <= '0;
      wkLevel_q     <= '0;
    end
    else
    begin
      strapDev_q    <= strapDev_d;
      strapPullup_q <= strapPullup_d;
      strapTaken_q  <= strapTaken_d;
      gpLevel_q     <= gpLevel_d;
      wkLevel_q     <= wkLevel_d;
    end
  end

  // Registers the read answer.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      readData_q  <= RESET_STATUS;
      readValid_q <= 1'b0;
    end
    else
    begin
      readData_q  <= readData_d;
      readValid_q <= readValid_d;
    end
  end

  // Registers the overload caution flag.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      caution_q <= 1'b0;
    end
    else
    begin
      caution_q <= caution_d;
    end
  end

  assign readData          = readData_q;
  assign readValid         = readValid_q;
  assign hsOverloadCaution = caution_q;
  assign lin2TxEnable      = txEnableRaw;

endmodule

// *** bwsb_status_bank_monitor.sv ***
// Checker for the status bank: read timing, flag latching, clears and transmitter recovery.
// Assumes it is bound to the bank and sees only the bank's ports.
`timescale 1ns/1ps
module bwsb_status_bank_monitor
  import bwsb_pkg::*;
#(
  parameter int unsigned ENABLE_CYCLES = TX_ENABLE_CYCLES
)
(
  input wire logic                clk,
  input wire logic                resetn,
  input wire logic                softReset,
  input wire logic                accessValid,
  input wire logic                accessWrite,
  input wire logic [ADDR_W-1:0]   accessAddr,
  input wire logic [DATA_W-1:0]   writeData,
  input wire logic [DATA_W-1:0]   readData,
  input wire logic                readValid,
  input wire bwsb_lin_t           lin2,
  input wire logic                lin2TxEnable,
  input wire bwsb_wake_t          wakeEvent,
  input wire logic                failSafeWake,
  input wire bwsb_wake_t          failSafeWakeSrc,
  input wire bwsb_mode_t          sbcMode,
  input wire bwsb_gp_cfg_t        gpCfg1,
  input wire bwsb_gp_cfg_t        gpCfg2,
  input wire logic [GP_COUNT-1:0] gpPinLevel,
  input wire logic [WK_COUNT-1:0] wakePinLevel,
  input wire logic                cyclicActive,
  input wire logic                sampleStrobe,
  input wire logic [WK_COUNT-1:0] sampledLevel,
  input wire logic                testPinStrap,
  input wire logic                intPullupDetect,
  input wire logic [HS_COUNT-1:0] hsOverloadEvt,
  input wire logic [HS_COUNT-1:0] hsOpenLoadEvt,
  input wire logic                supplyLowRange,
  input wire logic                hsOverloadCaution
);
  logic [15:0] hiCnt_q;
  logic [15:0] hiCnt_d;
  logic        rd;
  logic        quiet;

  assign rd    = accessValid && !accessWrite;
  assign quiet = !softReset && !failSafeWake && wakeEvent == '0 && hsOverloadEvt == '0
                 && hsOpenLoadEvt == '0 && !lin2.thermal && !lin2.txdTimeout && !lin2.busTimeout;

  // Counts consecutive cycles with the transmit input high.
  always_comb
  begin
    hiCnt_d = !lin2.txdHigh ? 16'h0000 : (&hiCnt_q) ? hiCnt_q : hiCnt_q + 16'h0001;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      hiCnt_q <= 16'h0000;
    else
      hiCnt_q <= hiCnt_d;
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  sequence s_read(a);
    rd && quiet && accessAddr == a;
  endsequence

  sequence s_settle;
    quiet && !accessValid;
  endsequence

  a_read_answer: assert property (rd |=> readValid)
    else $error("read request got no answer");
  a_reserved_zero: assert property (rd && accessAddr == ADDR_SECOND_LIN_BUS_STATUS |=>
    readData[7:3] == 5'h00 && !readData[0]) else $error("reserved bits not zero");
  a_soft_clear: assert property (softReset ##1 quiet ##1 (rd && quiet &&
    accessAddr != ADDR_WAKE_INPUT_LEVEL_STATUS) |=> readData == 8'h00)
    else $error("flags survived soft reset");
  a_clear_zero: assert property ((accessValid && accessWrite && writeData == 8'h00 &&
    quiet && accessAddr != ADDR_WAKE_INPUT_LEVEL_STATUS) ##1 quiet ##1
    (rd && quiet && accessAddr == $past(accessAddr, 2)) |=> readData == 8'h00)
    else $error("cleared register not zero");
  a_timer_latch: assert property ((wakeEvent.timer && !softReset) ##1 s_settle ##1
    s_read(ADDR_WAKE_SOURCE_STATUS_ONE) |=> readData[4]) else $error("timer wake lost");
  a_overload_latch: assert property ((hsOverloadEvt[3] && !softReset) ##1 s_settle ##1
    s_read(ADDR_HIGH_SIDE_OVERLOAD_STATUS) |=> readData[3]) else $error("overload lost");
  a_strap_bits: assert property (s_read(ADDR_WAKE_INPUT_LEVEL_STATUS) |=>
    readData[7:6] == {testPinStrap, intPullupDetect}) else $error("strap bits wrong");
  a_caution_copy: assert property (1'b1 |=> hsOverloadCaution == $past(supplyLowRange))
    else $error("caution flag wrong");
  a_tx_drop: assert property (lin2.thermal || !lin2.supplyOk |=> !lin2TxEnable)
    else $error("transmitter not disabled on fault");
  a_tx_hold: assert property (!lin2TxEnable && !lin2.txdHigh |=> !lin2TxEnable)
    else $error("transmitter enabled with input low");
  a_tx_rise: assert property ($rose(lin2TxEnable) |-> hiCnt_q >= ENABLE_CYCLES)
    else $error("transmitter enabled too early");
endmodule

bind bwsb_status_bank bwsb_status_bank_monitor #(.ENABLE_CYCLES(ENABLE_CYCLES)) mon (.*);

// *** bwsb_tx_recovery.sv ***
// Second LIN transmitter recovery tracker.
// Assumes transceiver detections arrive synchronous to clk.
`timescale 1ns/1ps
module bwsb_tx_recovery
  import bwsb_pkg::*;
#(
  parameter int unsigned ENABLE_CYCLES = TX_ENABLE_CYCLES
)
(
  input  wire logic      clk,
  input  wire logic      resetn,
  input  wire bwsb_lin_t lin,
  output logic           txEnable
);

  localparam int unsigned CNT_W = $clog2(ENABLE_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_DONE = CNT_W'(ENABLE_CYCLES);

  logic             txdDom_q;
  logic             txdDom_d;
  logic             busDom_q;
  logic             busDom_d;
  logic [CNT_W-1:0] highCnt_q;
  logic [CNT_W-1:0] highCnt_d;
  logic             txEnable_q;
  logic             txEnable_d;
  logic             faultActive;

  always_comb
  begin
    txdDom_d = txdDom_q;
    if (lin.txdHigh || lin.txOff)
    begin
      txdDom_d = 1'b0;
    end
    if (lin.txdTimeout)
    begin
      txdDom_d = 1'b1;
    end
    busDom_d = busDom_q;
    if (lin.busRecessive || lin.txOff)
    begin
      busDom_d = 1'b0;
    end
    if (lin.busTimeout)
    begin
      busDom_d = 1'b1;
    end
    faultActive = txdDom_d || busDom_d || lin.thermal || !lin.supplyOk;
    highCnt_d   = highCnt_q;
    txEnable_d  = txEnable_q;
    if (faultActive)
    begin
      txEnable_d = 1'b0;
      highCnt_d  = '0;
    end
    else if (!txEnable_q)
    begin
      if (!lin.txdHigh)
      begin
        highCnt_d = '0;
      end
      else if (highCnt_q + 1'b1 >= CNT_DONE)
      begin
        txEnable_d = 1'b1;
        highCnt_d  = '0;
      end
      else
      begin
        highCnt_d = highCnt_q + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      txdDom_q   <= 1'b0;
      busDom_q   <= 1'b0;
      highCnt_q  <= '0;
      txEnable_q <= 1'b1;
    end
    else
    begin
      txdDom_q   <= txdDom_d;
      busDom_q   <= busDom_d;
      highCnt_q  <= highCnt_d;
      txEnable_q <= txEnable_d;
    end
  end

  assign txEnable = txEnable_q;

endmodule

// *** tb_bwsb_status_bank.sv ***
// Self-checking bench for the status bank: flag sources, clears, levels and recovery.
// Assumes the host model issues every register access.
`timescale 1ns/1ps
module tb_bwsb_status_bank
  import bwsb_pkg::*;
;
  localparam bwsb_lin_t LIN_IDLE = 7'h0d;
  logic                clk, resetn, softReset, accessValid, accessWrite, readValid;
  logic [ADDR_W-1:0]   accessAddr;
  logic [DATA_W-1:0]   writeData, readData, q;
  bwsb_lin_t           lin2;
  logic                lin2TxEnable, failSafeWake, cyclicActive, sampleStrobe;
  bwsb_wake_t          wakeEvent, failSafeWakeSrc;
  bwsb_mode_t          sbcMode;
  bwsb_gp_cfg_t        gpCfg1, gpCfg2;
  logic [GP_COUNT-1:0] gpPinLevel;
  logic [WK_COUNT-1:0] wakePinLevel, sampledLevel;
  logic                testPinStrap, intPullupDetect, supplyLowRange, hsOverloadCaution;
  logic [HS_COUNT-1:0] hsOverloadEvt, hsOpenLoadEvt;
  int                  mismatches = 0;
  int                  check_count = 0;

  always #4 clk = ~clk;

  bwsb_status_bank #(.ENABLE_CYCLES(8)) dut (.*);

  bwsb_host_model host (.clk(clk), .readData(readData), .readValid(readValid),
    .accessValid(accessValid), .accessWrite(accessWrite), .accessAddr(accessAddr),
    .writeData(writeData));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rd(input logic [6:0] a, input logic [7:0] exp);
    host.access(1'b0, a, 8'h00, q);
    chk(q, exp);
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    host.access(1'b1, a, d, q);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Pulses events for one cycle; fs[1] is soft reset, fs[0] is fail-safe wake.
  task automatic evt(input bwsb_wake_t w, input logic [3:0] oc, input logic [3:0] ol,
                     input logic [1:0] fs);
    tick(1);
    wakeEvent <= w;
    hsOverloadEvt <= oc;
    hsOpenLoadEvt <= ol;
    {softReset, failSafeWake} <= fs;
    tick(1);
    wakeEvent <= '0;
    hsOverloadEvt <= 4'h0;
    hsOpenLoadEvt <= 4'h0;
    {softReset, failSafeWake} <= 2'b00;
  endtask

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    #50000;
    mismatches++;
    conclude();
  end

  initial
  begin
    clk = 1'b0;
    resetn = 1'b0;
    {softReset, failSafeWake, cyclicActive, sampleStrobe, supplyLowRange} = 5'h00;
    lin2 = LIN_IDLE;
    wakeEvent = '0;
    failSafeWakeSrc = 9'h080;
    sbcMode = BWSB_MODE_INIT;
    gpCfg1 = BWSB_GP_OFF;
    gpCfg2 = BWSB_GP_OFF;
    {gpPinLevel, wakePinLevel, sampledLevel} = 8'h00;
    {testPinStrap, intPullupDetect} = 2'b10;
    {hsOverloadEvt, hsOpenLoadEvt} = 8'h00;
    tick(20);
    resetn <= 1'b1;
    tick(2);
    rd(ADDR_SECOND_LIN_BUS_STATUS, 8'h00);
    rd(ADDR_WAKE_SOURCE_STATUS_ONE, 8'h00);
    rd(ADDR_WAKE_SOURCE_STATUS_TWO, 8'h00);
    rd(ADDR_HIGH_SIDE_OVERLOAD_STATUS, 8'h00);
    rd(ADDR_HIGH_SIDE_OPEN_LOAD_STATUS, 8'h00);
    rd(7'h7f, 8'h00);
    $display("Test reset values done");
    for (int i = 0; i < 3; i++)
    begin
      tick(1);
      lin2 <= LIN_IDLE | (7'h40 >> i);
      tick(1);
      lin2 <= LIN_IDLE;
      rd(ADDR_SECOND_LIN_BUS_STATUS, 8'((i + 1) * 2));
      rd(ADDR_SECOND_LIN_BUS_STATUS, 8'((i + 1) * 2));
      wr(ADDR_SECOND_LIN_BUS_STATUS, 8'h00);
      rd(ADDR_SECOND_LIN_BUS_STATUS, 8'h00);
    end
    tick(1);
    lin2 <= 7'h45;
    tick(1);
    lin2 <= 7'h05;
    tick(20);
    #1;
    chk({7'h00, lin2TxEnable}, 8'h00);
    tick(1);
    lin2 <= LIN_IDLE;
    tick(12);
    #1;
    chk({7'h00, lin2TxEnable}, 8'h01);
    wr(ADDR_SECOND_LIN_BUS_STATUS, 8'h00);
    tick(1);
    lin2 <= 7'h19;
    tick(1);
    lin2 <= 7'h09;
    tick(20);
    #1;
    chk({7'h00, lin2TxEnable}, 8'h00);
    tick(1);
    lin2 <= 7'h0b;
    tick(12);
    #1;
    chk({7'h00, lin2TxEnable}, 8'h01);
    rd(ADDR_SECOND_LIN_BUS_STATUS, 8'h06);
    tick(1);
    lin2 <= 7'h0c;
    tick(3);
    #1;
    chk({7'h00, lin2TxEnable}, 8'h00);
    tick(1);
    lin2 <= LIN_IDLE;
    tick(12);
    #1;
    chk({7'h00, lin2TxEnable}, 8'h01);
    wr(ADDR_SECOND_LIN_BUS_STATUS, 8'h00);
    $display("Test second LIN faults done");
    for (int i = 0; i < 9; i++)
    begin
      evt(9'(1 << i), 4'h0, 4'h0, 2'b00);
      rd(ADDR_WAKE_SOURCE_STATUS_ONE,
         i > 4 ? 8'(1 << (i - 1)) : i > 1 ? 8'(1 << (i - 2)) : 8'h00);
      rd(ADDR_WAKE_SOURCE_STATUS_TWO, i < 2 ? 8'(1 << (i + 4)) : 8'h00);
      wr(ADDR_WAKE_SOURCE_STATUS_ONE, 8'h00);
      wr(ADDR_WAKE_SOURCE_STATUS_TWO, 8'h00);
    end
    evt('0, 4'h0, 4'h0, 2'b01);
    rd(ADDR_WAKE_SOURCE_STATUS_ONE, 8'h40);
    wr(ADDR_WAKE_SOURCE_STATUS_ONE, 8'h00);
    $display("Test wake sources done");
    evt('0, 4'hf, 4'h5, 2'b00);
    rd(ADDR_HIGH_SIDE_OVERLOAD_STATUS, 8'h0f);
    rd(ADDR_HIGH_SIDE_OPEN_LOAD_STATUS, 8'h05);
    wr(ADDR_HIGH_SIDE_OVERLOAD_STATUS, 8'h0a);
    rd(ADDR_HIGH_SIDE_OVERLOAD_STATUS, 8'h0a);
    tick(1);
    sbcMode <= BWSB_MODE_RESTART;
    rd(ADDR_HIGH_SIDE_OVERLOAD_STATUS, 8'h0a);
    rd(ADDR_HIGH_SIDE_OPEN_LOAD_STATUS, 8'h05);
    evt(9'h1ff, 4'hf, 4'hf, 2'b10);
    rd(ADDR_HIGH_SIDE_OVERLOAD_STATUS, 8'h00);
    rd(ADDR_HIGH_SIDE_OPEN_LOAD_STATUS, 8'h00);
    rd(ADDR_WAKE_SOURCE_STATUS_ONE, 8'h00);
    $display("Test switch flags done");
    tick(1);
    sbcMode <= BWSB_MODE_NORMAL;
    gpCfg1 <= BWSB_GP_WAKE_INPUT;
    gpCfg2 <= BWSB_GP_HIGH_SIDE;
    gpPinLevel <= 2'b10;
    wakePinLevel <= 3'b101;
    tick(3);
    rd(ADDR_WAKE_INPUT_LEVEL_STATUS, 8'ha5);
    tick(1);
    sbcMode <= BWSB_MODE_SLEEP;
    gpPinLevel <= 2'b01;
    cyclicActive <= 1'b1;
    wakePinLevel <= 3'b110;
    sampledLevel <= 3'b011;
    tick(3);
    rd(ADDR_WAKE_INPUT_LEVEL_STATUS, 8'ha5);
    tick(1);
    sampleStrobe <= 1'b1;
    tick(1);
    sampleStrobe <= 1'b0;
    rd(ADDR_WAKE_INPUT_LEVEL_STATUS, 8'ha3);
    tick(1);
    cyclicActive <= 1'b0;
    sbcMode <= BWSB_MODE_STOP;
    gpCfg1 <= BWSB_GP_LOW_SIDE;
    gpCfg2 <= BWSB_GP_OFF;
    gpPinLevel <= 2'b11;
    wakePinLevel <= 3'b010;
    tick(3);
    rd(ADDR_WAKE_INPUT_LEVEL_STATUS, 8'hb2);
    tick(1);
    supplyLowRange <= 1'b1;
    tick(2);
    #1;
    chk({7'h00, hsOverloadCaution}, 8'h01);
    $display("Test levels and caution done");
    conclude();
  end
endmodule
